// ==== dac_code_and_control_registers.sv ====
// Operation
// - 24-bit frame: rw, address, data
// - 20-bit output code register, read/write
// - address 010 selects mode control
// - control field layout, reserved bits
// - amp bit 0: amp on, series
// - amp bit 1 default: amp off, parallel
// - clamp bit 0: normal mode when tristate bit is 0
// - clamp bit 1 default: clamp, tristate
// - reset leaves output clamped, tristated
// - clamp overrides tristate bit
// - tristate bit, resets to one
// - format bit: twos complement default
// - serial-output disable tristates data out
// - linearity field default zero
`timescale 1ns/1ps
`include "dac_regs_cfg.svh"
module dac_code_and_control_registers (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // serial link pins
  input wire logic sclk,
  input wire logic frame_sel_n,
  input wire logic sdin,
  output logic sdo,
  output logic sdo_oe,
  // converter controls
  output dac_regs_pkg::word20_t output_code,
  output logic code_format_select,
  output logic amp_config_select,
  output logic amp_powered,
  output logic fb_series,
  output logic output_ground_clamp,
  output logic output_tristate,
  output logic dac_driving,
  output dac_regs_pkg::lin_comp_t lin_comp
);
  import dac_regs_pkg::*;

  // ==========================================================
  // pin synchronisers
  logic sclk_s;
  logic sel_n_s;
  logic sdin_s;
  logic sclk_d;
  logic sel_n_d;

  // serial clock idles high; matching reset avoids a false edge
  pin_sync #(.RST_VAL(1'b1)) u_sync_sclk (
    .sys_clk(sys_clk), .resetn(resetn),
    .pin_in(sclk), .pin_sync_out(sclk_s));
  pin_sync #(.RST_VAL(1'b1)) u_sync_sel (
    .sys_clk(sys_clk), .resetn(resetn),
    .pin_in(frame_sel_n), .pin_sync_out(sel_n_s));
  pin_sync #(.RST_VAL(1'b0)) u_sync_sdin (
    .sys_clk(sys_clk), .resetn(resetn),
    .pin_in(sdin), .pin_sync_out(sdin_s));

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sclk_d <= 1'b1;
      sel_n_d <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      sel_n_d <= sel_n_s;
    end
  end

  logic sclk_fall;
  logic sclk_rise;
  logic sel_fall;
  logic sel_rise;
  assign sclk_fall = sclk_d && !sclk_s;
  assign sclk_rise = !sclk_d && sclk_s;
  assign sel_fall = sel_n_d && !sel_n_s;
  assign sel_rise = !sel_n_d && sel_n_s;

  // ==========================================================
  // frame shifter
  link_state_e state;
  logic [`FRAME_BITS-1:0] shift_in;
  logic [`FRAME_CNT_W-1:0] edge_cnt;
  logic frame_ok;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= LINK_IDLE;
      shift_in <= '0;
      edge_cnt <= '0;
    end else begin
      case (state)
        LINK_IDLE: begin
          if (sel_fall) begin
            state <= LINK_SHIFT;
            edge_cnt <= '0;
          end
        end
        LINK_SHIFT: begin
          if (sel_rise) begin
            state <= LINK_DONE;
          end else if (sclk_fall) begin
            shift_in <= {shift_in[`FRAME_BITS-2:0], sdin_s};
            if (edge_cnt != {`FRAME_CNT_W{1'b1}}) begin
              edge_cnt <= edge_cnt + 1'b1;
            end
          end
        end
        LINK_DONE: begin
          state <= LINK_IDLE;
        end
        default: begin
          state <= LINK_IDLE;
        end
      endcase
    end
  end

  // only exactly 24 falling edges commit a frame
  assign frame_ok = (state == LINK_DONE) &&
    (edge_cnt == `FRAME_CNT_W'(`FRAME_BITS));

  logic is_write;
  logic [2:0] frame_addr;
  word20_t frame_data;
  assign is_write = !shift_in[`RW_BIT];
  assign frame_addr = shift_in[`ADDR_HI:`ADDR_LO];
  assign frame_data = shift_in[`DATA_HI:0];

  // ==========================================================
  // registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      output_code <= `CODE_RST;
    end else if (frame_ok && is_write &&
                 frame_addr == `ADDR_CODE) begin
      output_code <= frame_data;
    end
  end

  logic sdo_dis;
  logic tri_bit;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lin_comp <= `LIN_RST;
      sdo_dis <= `SDO_DIS_RST;
      code_format_select <= `FMT_RST;
      tri_bit <= `TRI_RST;
      output_ground_clamp <= `CLAMP_RST;
      amp_config_select <= `AMP_RST;
    end else if (frame_ok && is_write &&
                 frame_addr == `ADDR_CTRL) begin
      lin_comp <= frame_data[`LIN_HI:`LIN_LO];
      sdo_dis <= frame_data[`SDO_DIS_BIT];
      code_format_select <= frame_data[`FMT_BIT];
      tri_bit <= frame_data[`TRI_BIT];
      output_ground_clamp <= frame_data[`CLAMP_BIT];
      amp_config_select <= frame_data[`AMP_BIT];
    end
  end

  // derived converter controls, registered
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      output_tristate <= `TRI_RST | `CLAMP_RST;
      dac_driving <= ~`TRI_RST & ~`CLAMP_RST;
      amp_powered <= ~`AMP_RST;
      fb_series <= ~`AMP_RST;
    end else begin
      output_tristate <= tri_bit || output_ground_clamp;
      dac_driving <= !tri_bit && !output_ground_clamp;
      amp_powered <= !amp_config_select;
      fb_series <= !amp_config_select;
    end
  end

  // ==========================================================
  // readback: addressed register shifts out in the next frame
  logic [`FRAME_BITS-1:0] shift_out;
  logic [`FRAME_BITS-1:0] rd_word;
  word20_t ctrl_view;
  always_comb begin
    ctrl_view = '0;
    ctrl_view[`LIN_HI:`LIN_LO] = lin_comp;
    ctrl_view[`SDO_DIS_BIT] = sdo_dis;
    ctrl_view[`FMT_BIT] = code_format_select;
    ctrl_view[`TRI_BIT] = tri_bit;
    ctrl_view[`CLAMP_BIT] = output_ground_clamp;
    ctrl_view[`AMP_BIT] = amp_config_select;
    rd_word = '0;
    if (frame_addr == `ADDR_CODE) begin
      rd_word = {shift_in[`RW_BIT:`ADDR_LO], output_code};
    end else if (frame_addr == `ADDR_CTRL) begin
      rd_word = {shift_in[`RW_BIT:`ADDR_LO], ctrl_view};
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      shift_out <= '0;
    end else if (frame_ok && !is_write) begin
      shift_out <= rd_word;
    end else if (state == LINK_IDLE && sel_fall) begin
      shift_out <= shift_out;
    end else if (state == LINK_SHIFT && sclk_fall && !sel_rise) begin
      shift_out <= {shift_out[`FRAME_BITS-2:0], 1'b0};
    end else if (frame_ok) begin
      shift_out <= '0;
    end
  end

  // data out changes on rising sclk, host samples on falling
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      sdo_oe <= !sel_n_s && !sdo_dis;
      if (state == LINK_IDLE && sel_fall) begin
        sdo <= shift_out[`FRAME_BITS-1];
      end else if (sclk_rise) begin
        sdo <= shift_out[`FRAME_BITS-1];
      end
    end
  end

  // ==========================================================
  // checks
  clamp_tri_a: assert property (@(posedge sys_clk)
    disable iff (!resetn) output_ground_clamp |=> output_tristate)
    else $error("clamp did not force tristate");
  drive_mode_a: assert property (@(posedge sys_clk)
    disable iff (!resetn) dac_driving |-> !output_tristate)
    else $error("driving while tristated");
  amp_series_a: assert property (@(posedge sys_clk)
    disable iff (!resetn) !amp_config_select |=> amp_powered && fb_series)
    else $error("amp not configured for series");
  amp_parallel_a: assert property (@(posedge sys_clk)
    disable iff (!resetn) amp_config_select |=> !amp_powered && !fb_series)
    else $error("amp not configured for parallel");
  bad_frame_a: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    (state == LINK_DONE && edge_cnt != `FRAME_CNT_W'(`FRAME_BITS)) |=>
      $stable(output_code))
    else $error("short or long frame changed code");
  code_write_a: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    (frame_ok && is_write && frame_addr == `ADDR_CODE) |=>
      output_code == $past(frame_data))
    else $error("code write lost");
  sdo_off_a: assert property (@(posedge sys_clk)
    disable iff (!resetn) sdo_dis |=> !sdo_oe)
    else $error("data out driven while disabled");
  ctrl_view_a: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    ctrl_view[`DATA_HI:`LIN_HI+1] == '0 && !ctrl_view[`RSV_LO_BIT])
    else $error("reserved bits not zero");
endmodule : dac_code_and_control_registers

// ==== dac_regs_cfg.svh ====
`ifndef DAC_REGS_CFG_SVH
`define DAC_REGS_CFG_SVH
// frame layout
`define FRAME_BITS 24
`define FRAME_CNT_W 5
`define RW_BIT 23
`define ADDR_HI 22
`define ADDR_LO 20
`define DATA_HI 19
`define DATA_W 20
// register addresses
`define ADDR_NOP 3'h0
`define ADDR_CODE 3'h1
`define ADDR_CTRL 3'h2
// control fields
`define LIN_HI 9
`define LIN_LO 6
`define SDO_DIS_BIT 5
`define FMT_BIT 4
`define TRI_BIT 3
`define CLAMP_BIT 2
`define AMP_BIT 1
`define RSV_LO_BIT 0
// reset values
`define CODE_RST 20'h00000
`define LIN_RST 4'h0
`define SDO_DIS_RST 1'h0
`define FMT_RST 1'h0
`define TRI_RST 1'h1
`define CLAMP_RST 1'h1
`define AMP_RST 1'h1
`endif

// ==== dac_regs_pkg.sv ====
package dac_regs_pkg;
  typedef logic [19:0] word20_t;
  typedef logic [3:0] lin_comp_t;
  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_SHIFT = 2'b01,
    LINK_DONE = 2'b10
  } link_state_e;
endpackage : dac_regs_pkg

// ==== pin_sync.sv ====
`timescale 1ns/1ps
// two-stage synchroniser for pins
module pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // level
  input wire logic pin_in,
  output logic pin_sync_out
);
  logic meta;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta <= RST_VAL;
      pin_sync_out <= RST_VAL;
    end else begin
      meta <= pin_in;
      pin_sync_out <= meta;
    end
  end
endmodule : pin_sync

// ==== host_link_model.sv ====
`timescale 1ns/1ps
// ====================
// host side of the serial link; clock idles high between frames
module host_link_model (
  // serial link
  output logic sclk,
  output logic frame_sel_n,
  output logic sdin,
  input wire logic sdo,
  input wire logic sdo_oe
);
  logic oe_seen;
  initial begin
    sclk = 1'b1;
    frame_sel_n = 1'b1;
    sdin = 1'b0;
    oe_seen = 1'b0;
  end
  // n falling edges, msb first; sdo is taken at each fall
  task automatic xfer(input int n, input logic [23:0] w,
    output logic [23:0] r);
    r = 24'h000000;
    oe_seen = 1'b0;
    frame_sel_n = 1'b0;
    #40;
    for (int i = 0; i < n; i++) begin
      sdin = w[23 - (i % 24)];
      #62.5 sclk = 1'b0;
      r = {r[22:0], sdo_oe ? sdo : 1'bz};
      oe_seen = oe_seen | sdo_oe;
      #62.5 sclk = 1'b1;
    end
    #40 frame_sel_n = 1'b1;
    // a released line does not keep its last value
    sdin = ~sdin;
    #100;
  endtask : xfer
endmodule : host_link_model

// ==== dac_code_and_control_registers_bench.sv ====
`timescale 1ns/1ps
module dac_code_and_control_registers_bench;
  import dac_regs_pkg::*;
  // ====================
  // signals and instances
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic sclk, frame_sel_n, sdin, sdo, sdo_oe;
  logic fmt_o, amp_o, amp_on, series, clamp_o, tri_o, driving;
  word20_t code_o;
  lin_comp_t lin_o;
  logic [23:0] rd;
  int fail_count = 0;
  int n_compared = 0;
  always #2.5 sys_clk = ~sys_clk;
  dac_code_and_control_registers DUT (
    .sys_clk(sys_clk), .resetn(resetn), .sclk(sclk),
    .frame_sel_n(frame_sel_n), .sdin(sdin), .sdo(sdo), .sdo_oe(sdo_oe),
    .output_code(code_o), .code_format_select(fmt_o),
    .amp_config_select(amp_o), .amp_powered(amp_on), .fb_series(series),
    .output_ground_clamp(clamp_o), .output_tristate(tri_o),
    .dac_driving(driving), .lin_comp(lin_o));
  host_link_model host (.sclk(sclk), .frame_sel_n(frame_sel_n),
    .sdin(sdin), .sdo(sdo), .sdo_oe(sdo_oe));
  // ====================
  // tasks
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check
  task automatic ctl_is(input logic [3:0] lin, input logic fmt, tb, cl, am);
    check(24'({fmt_o, amp_o, amp_on, series, clamp_o, tri_o,
      driving, lin_o}),
      24'({fmt, am, ~am, ~am, cl, cl | tb, ~cl & ~tb, lin}));
  endtask : ctl_is
  // write control with reserved bits zero, then read it back
  task automatic cfg(input logic [3:0] lin, input logic sd, fmt, tb, cl, am);
    host.xfer(24, {4'h2, 10'h0, lin, sd, fmt, tb, cl, am, 1'b0}, rd);
    ctl_is(lin, fmt, tb, cl, am);
    host.xfer(24, 24'hA00000, rd);
    host.xfer(24, 24'h000000, rd);
    if (sd == 1'b0)
      check(rd, {4'hA, 10'h0, lin, sd, fmt, tb, cl, am, 1'b0});
  endtask : cfg
  task automatic apply_reset;
    @(posedge sys_clk);
    #1 resetn = 1'b0;
    repeat (12) @(posedge sys_clk);
    #1 resetn = 1'b1;
    repeat (4) @(posedge sys_clk);
    // keep every later pin change and check off the clock edge
    #1;
  endtask : apply_reset
  task automatic t_defaults;
    apply_reset();
    ctl_is(4'h0, 1'b0, 1'b1, 1'b1, 1'b1);
    check(24'(code_o), 24'h000000);
    check(24'(sdo_oe), 24'h000000);
    host.xfer(24, 24'hA00000, rd);
    host.xfer(24, 24'h000000, rd);
    check(rd, 24'hA0000E);
  endtask : t_defaults
  task automatic t_code;
    host.xfer(24, 24'h1A5C3F, rd);
    check(24'(code_o), 24'h0A5C3F);
    host.xfer(24, 24'h900000, rd);
    host.xfer(24, 24'h15A3C0, rd);
    check(rd, 24'h9A5C3F);
    check(24'(code_o), 24'h05A3C0);
  endtask : t_code
  task automatic t_bad_frames;
    host.xfer(23, 24'h112345, rd);
    host.xfer(25, 24'h112345, rd);
    host.xfer(23, 24'h200000, rd);
    host.xfer(24, 24'h312345, rd);
    check(24'(code_o), 24'h05A3C0);
    ctl_is(4'h0, 1'b0, 1'b1, 1'b1, 1'b1);
    // an unmapped read loads an all-zero word, header included
    host.xfer(24, 24'hD00000, rd);
    host.xfer(24, 24'h000000, rd);
    check(rd, 24'h000000);
  endtask : t_bad_frames
  task automatic t_modes;
    cfg(4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    cfg(4'h9, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    cfg(4'hA, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    cfg(4'hB, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    cfg(4'hC, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
  endtask : t_modes
  task automatic t_sdo_off;
    cfg(4'h0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
    check(24'(host.oe_seen), 24'h000000);
    cfg(4'h0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    check(24'(host.oe_seen), 24'h000001);
  endtask : t_sdo_off
  task automatic t_rereset;
    cfg(4'h9, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    t_defaults();
  endtask : t_rereset
  task automatic end_of_test;
    $display("compared %0d, failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  initial begin
    t_defaults();
    t_code();
    t_bad_frames();
    t_modes();
    t_sdo_off();
    t_rereset();
    end_of_test();
  end
  // watchdog, several times the expected run length
  initial begin
    #400000;
    fail_count++;
    end_of_test();
  end
endmodule : dac_code_and_control_registers_bench
